// ==== rtl/sgf_pkg.sv ====
// Constants, field layouts and types for the on-demand serial block.
// Assumes a 32-bit AXI4-Lite register bus with word-indexed registers.
package sgf_pkg;
  // ==========================================================
  // Register indexes (byte address is four times the index)
  localparam logic [15:0] IDX_CTRL_A = 16'hFFEC;
  localparam logic [15:0] IDX_CTRL_B = 16'hFFED;
  localparam logic [15:0] IDX_STATUS = 16'hFFEE;
  localparam logic [15:0] IDX_DATA = 16'hFFEF;
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned WORD_W = 24;
  // ==========================================================
  // Reset values
  localparam logic [23:0] CTRL_A_RST = 24'h000000;
  localparam logic [23:0] CTRL_B_RST = 24'h000000;
  localparam logic [23:0] DATA_RST = 24'h000000;
  // ==========================================================
  // Status bit positions
  localparam int unsigned ST_IN_FLAG0 = 0;
  localparam int unsigned ST_IN_FLAG1 = 1;
  localparam int unsigned ST_UNDERRUN = 4;
  localparam int unsigned ST_TX_EMPTY = 6;
  localparam int unsigned ST_RX_FULL = 7;
  // ==========================================================
  // Word length codes and gap length
  localparam logic [1:0] WL_8 = 2'h0;
  localparam logic [1:0] WL_12 = 2'h1;
  localparam logic [1:0] WL_16 = 2'h2;
  localparam logic [1:0] WL_24 = 2'h3;
  localparam int unsigned GAP_BITS = 2;
  localparam logic [4:0] GAP_HALVES = 5'(GAP_BITS * 2);
  localparam logic [4:0] LAST_BIT_8 = 5'h07;
  localparam logic [4:0] LAST_BIT_12 = 5'h0B;
  localparam logic [4:0] LAST_BIT_16 = 5'h0F;
  localparam logic [4:0] LAST_BIT_24 = 5'h17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Field layouts
  typedef struct packed {
    logic [8:0] unused;
    logic [1:0] word_len;
    logic [4:0] frame_divide_ratio;
    logic [7:0] bit_clk_div;
  } sgf_ctrl_a_s;
  typedef struct packed {
    logic [7:0] unused;
    logic receiver_on;
    logic transmitter_on;
    logic rx_irq_en;
    logic tx_irq_en;
    logic network_mode_sel;
    logic gated_clk_sel;
    logic unused_b;
    logic sync_mode_sel;
    logic [1:0] unused_a;
    logic bit_clk_dir;
    logic ctl_pin2_dir;
    logic ctl_pin1_dir;
    logic ctl_pin0_dir;
    logic out_flag_bit1;
    logic out_flag_bit0;
  } sgf_ctrl_b_s;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_GAP = 2'b10
  } sgf_state_e;
endpackage

// ==== rtl/sgf_serial.sv ====
// On-demand gated-clock serial port with double-buffered flag pins.
// Assumes an AXI4-Lite master on mclk_i and pins from another domain.
`timescale 1ns/100ps
`default_nettype none
module sgf_serial
  import sgf_pkg::*;
#(
  parameter int unsigned AW = ADDR_W
) (
  input wire logic mclk_i,
  input wire logic rstn_i,
  input wire logic [AW-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [AW-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic bit_clk_o,
  output logic bit_clk_oe_n_o,
  input wire logic bit_clk_i,
  output logic tx_data_pin_o,
  output logic tx_data_pin_oe_n_o,
  input wire logic rx_data_pin_i,
  input wire logic serial_ctl_pin0_i,
  output logic serial_ctl_pin0_o,
  output logic serial_ctl_pin0_oe_n_o,
  input wire logic serial_ctl_pin1_i,
  output logic serial_ctl_pin1_o,
  output logic serial_ctl_pin1_oe_n_o,
  output logic serial_ctl_pin2_o,
  output logic serial_ctl_pin2_oe_n_o,
  output logic tx_irq_o,
  output logic rx_irq_o
);
  // ==========================================================
  // Elaboration check
  if (AW < 18 || AW > 32) begin : g_chk
    $error("sgf_serial: AW must be 18..32");
  end

  // ==========================================================
  // Declarations
  logic [23:0] ctrl_a_q, ctrl_b_q, txd_q, rxd_q, tsr_q, rsh_q;
  sgf_ctrl_a_s serial_control_a;
  sgf_ctrl_b_s serial_control_b;
  logic tde_q, rdf_q, bclk_q, std_oe_n_q, fs_q;
  logic [1:0] of_q, if_q;
  sgf_state_e state_q;
  logic [7:0] half_q;
  logic [4:0] bit_q, rx_cnt_q, wl_last;
  logic aw_got_q, w_got_q;
  logic [AW-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [3:0] s1_q, s2_q, s3_q, filt_q;
  logic ext_clk_prev_q;
  logic wr_now, wr_tx, rd_take, rd_rx, half_tick, ondemand, go, load;
  logic rx_tick, rx_done;
  logic [23:0] wr_val;

  assign serial_control_a = sgf_ctrl_a_s'(ctrl_a_q);
  assign serial_control_b = sgf_ctrl_b_s'(ctrl_b_q);

  // ==========================================================
  // Pin input synchronisers
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s1_q <= 4'h0;
      s2_q <= 4'h0;
      s3_q <= 4'h0;
      filt_q <= 4'h0;
      ext_clk_prev_q <= 1'b0;
    end else begin
      s1_q <= {serial_ctl_pin1_i, serial_ctl_pin0_i, rx_data_pin_i, bit_clk_i};
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
      ext_clk_prev_q <= filt_q[0];
    end
  end

  // ==========================================================
  // AXI4-Lite write path
  function automatic logic [23:0] merge(input logic [23:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [23:0] r;
    r = old;
    for (int i = 0; i < 3; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign wr_now = aw_got_q && w_got_q && !s_axi_bvalid_o;
  assign wr_tx = wr_now && (awaddr_q[AW-1:2] == (AW-2)'(IDX_DATA));

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_got_q <= 1'b1;
        awaddr_q <= s_axi_awaddr_i;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_got_q <= 1'b1;
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
        s_axi_wready_o <= 1'b0;
      end
      if (wr_now) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        case (awaddr_q[AW-1:2])
          (AW-2)'(IDX_CTRL_A), (AW-2)'(IDX_CTRL_B), (AW-2)'(IDX_DATA): begin
            s_axi_bresp_o <= RESP_OKAY;
          end
          default: begin
            s_axi_bresp_o <= RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // Control and transmit data registers
  assign wr_val = (awaddr_q[AW-1:2] == (AW-2)'(IDX_DATA)) ? merge(txd_q, wdata_q, wstrb_q) :
                  (awaddr_q[AW-1:2] == (AW-2)'(IDX_CTRL_A)) ? merge(ctrl_a_q, wdata_q, wstrb_q) :
                  merge(ctrl_b_q, wdata_q, wstrb_q);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl_a_q <= CTRL_A_RST;
      ctrl_b_q <= CTRL_B_RST;
      txd_q <= DATA_RST;
    end else if (wr_now) begin
      if (awaddr_q[AW-1:2] == (AW-2)'(IDX_CTRL_A)) begin
        ctrl_a_q <= wr_val;
      end
      if (awaddr_q[AW-1:2] == (AW-2)'(IDX_CTRL_B)) begin
        ctrl_b_q <= wr_val;
      end
      if (wr_tx) begin
        txd_q <= wr_val;
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read path
  assign rd_take = s_axi_arvalid_i && s_axi_arready_o;
  assign rd_rx = rd_take && (s_axi_araddr_i[AW-1:2] == (AW-2)'(IDX_DATA));

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h00000000;
      s_axi_rresp_o <= RESP_OKAY;
    end else begin
      if (rd_take) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= RESP_OKAY;
        s_axi_rdata_o <= 32'h00000000;
        case (s_axi_araddr_i[AW-1:2])
          (AW-2)'(IDX_CTRL_A): begin
            s_axi_rdata_o <= {8'h00, ctrl_a_q};
          end
          (AW-2)'(IDX_CTRL_B): begin
            s_axi_rdata_o <= {8'h00, ctrl_b_q};
          end
          (AW-2)'(IDX_STATUS): begin
            s_axi_rdata_o[ST_RX_FULL] <= rdf_q;
            s_axi_rdata_o[ST_TX_EMPTY] <= tde_q;
            s_axi_rdata_o[ST_UNDERRUN] <= 1'b0;
            s_axi_rdata_o[ST_IN_FLAG1] <= if_q[1];
            s_axi_rdata_o[ST_IN_FLAG0] <= if_q[0];
          end
          (AW-2)'(IDX_DATA): begin
            s_axi_rdata_o <= {8'h00, rxd_q};
          end
          default: begin
            s_axi_rresp_o <= RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid_o && s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Transmit engine
  always_comb begin
    case (serial_control_a.word_len)
      WL_8: wl_last = LAST_BIT_8;
      WL_12: wl_last = LAST_BIT_12;
      WL_16: wl_last = LAST_BIT_16;
      default: wl_last = LAST_BIT_24;
    endcase
  end

  assign ondemand = serial_control_b.network_mode_sel && (serial_control_a.frame_divide_ratio == 5'h00);
  assign go = ondemand && serial_control_b.gated_clk_sel && serial_control_b.bit_clk_dir && serial_control_b.transmitter_on;
  assign load = (state_q == ST_IDLE) && go && !tde_q && !wr_tx;
  assign half_tick = (half_q == serial_control_a.bit_clk_div);

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tde_q <= 1'b1;
    end else if (wr_tx) begin
      tde_q <= 1'b0;
    end else if (load) begin
      tde_q <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= ST_IDLE;
      half_q <= 8'h00;
      bit_q <= 5'h00;
      bclk_q <= 1'b0;
      tsr_q <= DATA_RST;
      std_oe_n_q <= 1'b1;
      fs_q <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          half_q <= 8'h00;
          bit_q <= 5'h00;
          bclk_q <= 1'b0;
          if (load) begin
            tsr_q <= txd_q;
            std_oe_n_q <= 1'b0;
            fs_q <= 1'b1;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          half_q <= half_tick ? 8'h00 : half_q + 8'h01;
          if (half_tick) begin
            bclk_q <= !bclk_q;
            if (bclk_q) begin
              if (bit_q == wl_last) begin
                bit_q <= 5'h00;
                std_oe_n_q <= 1'b1;
                fs_q <= 1'b0;
                state_q <= ST_GAP;
              end else begin
                bit_q <= bit_q + 5'h01;
                tsr_q <= {tsr_q[22:0], 1'b0};
              end
            end
          end
        end
        ST_GAP: begin
          half_q <= half_tick ? 8'h00 : half_q + 8'h01;
          bclk_q <= 1'b0;
          if (half_tick) begin
            if (bit_q == GAP_HALVES - 5'h01) begin
              bit_q <= 5'h00;
              state_q <= ST_IDLE;
            end else begin
              bit_q <= bit_q + 5'h01;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Output flags, double buffered
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      of_q <= 2'b00;
    end else if (!serial_control_b.transmitter_on) begin
      of_q <= {serial_control_b.out_flag_bit1, serial_control_b.out_flag_bit0};
    end else if (load) begin
      of_q <= {serial_control_b.out_flag_bit1, serial_control_b.out_flag_bit0};
    end
  end

  // ==========================================================
  // Receive engine
  assign rx_tick = serial_control_b.receiver_on &&
                   (serial_control_b.bit_clk_dir ? (state_q == ST_SHIFT && half_tick && !bclk_q)
                                    : (filt_q[0] && !ext_clk_prev_q));
  assign rx_done = rx_tick && (rx_cnt_q == wl_last);

  function automatic logic [23:0] align(input logic [23:0] v, input logic [1:0] wl);
    case (wl)
      WL_8: return {v[7:0], 16'h0000};
      WL_12: return {v[11:0], 12'h000};
      WL_16: return {v[15:0], 8'h00};
      default: return v;
    endcase
  endfunction

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_cnt_q <= 5'h00;
      rsh_q <= DATA_RST;
      rxd_q <= DATA_RST;
      if_q <= 2'b00;
    end else if (!serial_control_b.receiver_on) begin
      rx_cnt_q <= 5'h00;
    end else if (rx_tick) begin
      rsh_q <= {rsh_q[22:0], filt_q[1]};
      if (rx_cnt_q == 5'h00) begin
        if_q <= filt_q[3:2];
      end
      if (rx_done) begin
        rx_cnt_q <= 5'h00;
        rxd_q <= align({rsh_q[22:0], filt_q[1]}, serial_control_a.word_len);
      end else begin
        rx_cnt_q <= rx_cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdf_q <= 1'b0;
    end else if (rx_done) begin
      rdf_q <= 1'b1;
    end else if (rd_rx) begin
      rdf_q <= 1'b0;
    end
  end

  // ==========================================================
  // Pin and interrupt outputs
  always_ff @(posedge mclk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_ctl_pin0_oe_n_o <= 1'b1;
      serial_ctl_pin1_oe_n_o <= 1'b1;
      serial_ctl_pin2_oe_n_o <= 1'b1;
      bit_clk_oe_n_o <= 1'b1;
      tx_irq_o <= 1'b0;
      rx_irq_o <= 1'b0;
    end else begin
      serial_ctl_pin0_oe_n_o <= !(serial_control_b.sync_mode_sel && serial_control_b.ctl_pin0_dir);
      serial_ctl_pin1_oe_n_o <= !(serial_control_b.sync_mode_sel && serial_control_b.ctl_pin1_dir);
      serial_ctl_pin2_oe_n_o <= !serial_control_b.ctl_pin2_dir;
      bit_clk_oe_n_o <= !serial_control_b.bit_clk_dir;
      tx_irq_o <= serial_control_b.tx_irq_en && tde_q;
      rx_irq_o <= serial_control_b.rx_irq_en && rdf_q;
    end
  end

  assign bit_clk_o = bclk_q;
  assign tx_data_pin_o = tsr_q[23];
  assign tx_data_pin_oe_n_o = std_oe_n_q;
  assign serial_ctl_pin0_o = of_q[0];
  assign serial_ctl_pin1_o = of_q[1];
  assign serial_ctl_pin2_o = fs_q;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_word_start;
    load;
  endsequence
  sequence s_gap_entry;
    (state_q == ST_SHIFT) ##1 (state_q == ST_GAP);
  endsequence

  property p_load_sets_empty;
    s_word_start |=> tde_q && (state_q == ST_SHIFT) && (tsr_q == $past(txd_q));
  endproperty
  a_load_sets_empty: assert property (p_load_sets_empty) else $error("load lost");

  property p_write_clears_empty;
    wr_tx |=> !tde_q;
  endproperty
  a_write_clears_empty: assert property (p_write_clears_empty) else $error("empty stuck");

  property p_idle_quiet;
    (state_q != ST_SHIFT) |-> tx_data_pin_oe_n_o && !bit_clk_o;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("pin driven idle");

  property p_gap_len;
    s_gap_entry |-> ((state_q == ST_GAP) && !bit_clk_o) [*4];
  endproperty
  a_gap_len: assert property (p_gap_len) else $error("gap short");

  property p_start_needs_go;
    (state_q == ST_IDLE) && !(go && !tde_q) |=> (state_q != ST_SHIFT);
  endproperty
  a_start_needs_go: assert property (p_start_needs_go) else $error("clock without data");

  property p_full_set;
    rx_done |=> rdf_q && (rxd_q == align($past(rsh_q << 1) | 24'($past(filt_q[1])),
                                         $past(serial_control_a.word_len)));
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag missing");

  property p_oflag_hold;
    serial_control_b.transmitter_on && !load && $past(serial_control_b.transmitter_on) |=> $stable(of_q);
  endproperty
  a_oflag_hold: assert property (p_oflag_hold) else $error("out flag moved");

  property p_dir;
    serial_control_b.sync_mode_sel && serial_control_b.ctl_pin0_dir |=> !serial_ctl_pin0_oe_n_o;
  endproperty
  a_dir: assert property (p_dir) else $error("flag pin direction");

  property p_irq;
    serial_control_b.tx_irq_en && tde_q |=> tx_irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("empty irq missing");

  property p_iflag_hold;
    !(rx_tick && rx_cnt_q == 5'h00) |=> $stable(if_q);
  endproperty
  a_iflag_hold: assert property (p_iflag_hold) else $error("in flag moved");
endmodule
`default_nettype wire

// ==== bench/sgf_peer.sv ====
// Far-side serial peer: captures gated-clock words, sends on its own clock.
// Assumes the gated clock idles low and data is sampled on its rising edge.
`timescale 1ns/100ps
`default_nettype none
module sgf_peer (
  input wire logic bit_clk_o,
  input wire logic tx_data_pin_o,
  input wire logic tx_data_pin_oe_n_o,
  output logic bit_clk_i,
  output logic rx_data_pin_i
);
  logic [23:0] got;
  int bits;
  initial begin
    bit_clk_i = 1'b0;
    rx_data_pin_i = 1'b0;
    got = 24'h000000;
    bits = 0;
  end
  // ====================
  // Capture, word framed by clock rises while the data pin is enabled
  always @(posedge bit_clk_o) begin
    if (tx_data_pin_oe_n_o === 1'b0) begin
      got <= {got[22:0], tx_data_pin_o};
      bits <= bits + 1;
    end
  end
  // ====================
  // Send, clock still outside the word
  task automatic send(input logic [7:0] w);
    #7;
    for (int i = 7; i >= 0; i--) begin
      rx_data_pin_i = w[i];
      #160 bit_clk_i = 1'b1;
      #160 bit_clk_i = 1'b0;
    end
    rx_data_pin_i = ~rx_data_pin_i;
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// Self-checking bench for the on-demand serial block.
// Assumes AXI4-Lite register access and the peer model beside it.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sgf_pkg::*;
  localparam logic [17:0] A_CA = {IDX_CTRL_A, 2'b00};
  localparam logic [17:0] A_CB = {IDX_CTRL_B, 2'b00};
  localparam logic [17:0] A_ST = {IDX_STATUS, 2'b00};
  localparam logic [17:0] A_DT = {IDX_DATA, 2'b00};
  logic mclk_i, rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i;
  logic s_axi_arvalid_i, s_axi_rready_i, s_axi_awready_o, s_axi_wready_o;
  logic s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [17:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0] s_axi_wstrb_i;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o;
  logic bit_clk_o, bit_clk_oe_n_o, bit_clk_i, tx_data_pin_o, tx_data_pin_oe_n_o;
  logic rx_data_pin_i, serial_ctl_pin0_i, serial_ctl_pin0_o, serial_ctl_pin0_oe_n_o;
  logic serial_ctl_pin1_i, serial_ctl_pin1_o, serial_ctl_pin1_oe_n_o;
  logic serial_ctl_pin2_o, serial_ctl_pin2_oe_n_o, tx_irq_o, rx_irq_o;
  int error_cnt = 0;
  int checked = 0;
  logic clk_q = 1'b0;
  int rise_cnt = 0;
  int since_rise = 0;
  int max_gap = 0;

  sgf_serial dut (.mclk_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
    .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o,
    .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .bit_clk_o,
    .bit_clk_oe_n_o, .bit_clk_i, .tx_data_pin_o, .tx_data_pin_oe_n_o, .rx_data_pin_i,
    .serial_ctl_pin0_i, .serial_ctl_pin0_o, .serial_ctl_pin0_oe_n_o, .serial_ctl_pin1_i,
    .serial_ctl_pin1_o, .serial_ctl_pin1_oe_n_o, .serial_ctl_pin2_o,
    .serial_ctl_pin2_oe_n_o, .tx_irq_o, .rx_irq_o);
  sgf_peer peer (.bit_clk_o, .tx_data_pin_o, .tx_data_pin_oe_n_o, .bit_clk_i,
    .rx_data_pin_i);

  // ====================
  // Clock, watchdog and gated clock monitor
  initial begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (100000) @(posedge mclk_i);
    timeout_hit;
  end
  always @(posedge mclk_i) begin
    clk_q <= bit_clk_o;
    since_rise <= since_rise + 1;
    if (bit_clk_o === 1'b1 && clk_q === 1'b0) begin
      rise_cnt <= rise_cnt + 1;
      since_rise <= 0;
      if (rise_cnt > 0 && since_rise + 1 > max_gap) max_gap <= since_rise + 1;
    end
  end

  // ====================
  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkb(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: pin got %b expected %b", $time, got, exp);
    end
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task timeout_hit;
    error_cnt++;
    $display("wrong value at %0t: wait ran out", $time);
    final_report;
  endtask

  // ====================
  // Bus and timing helpers
  task automatic wr(input logic [17:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    logic [1:0] r;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    r = 2'h1;
    @(posedge mclk_i);
    s_axi_awaddr_i <= a;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wdata_i <= d;
    s_axi_wstrb_i <= 4'hF;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    for (int n = 0; n < 60 && r === 2'h1; n++) begin
      @(posedge mclk_i);
      if (aw_ok && w_ok && s_axi_bvalid_o === 1'b1) begin
        r = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
      end
      if (s_axi_awready_o === 1'b1 && s_axi_awvalid_i) begin
        aw_ok = 1'b1;
        s_axi_awvalid_i <= 1'b0;
      end
      if (s_axi_wready_o === 1'b1 && s_axi_wvalid_i) begin
        w_ok = 1'b1;
        s_axi_wvalid_i <= 1'b0;
      end
    end
    if (r === 2'h1) timeout_hit;
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic rd(input logic [17:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic a_ok;
    logic [1:0] r;
    logic [31:0] d;
    a_ok = 1'b0;
    r = 2'h1;
    d = 32'h0;
    @(posedge mclk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    for (int n = 0; n < 60 && r === 2'h1; n++) begin
      @(posedge mclk_i);
      if (a_ok && s_axi_rvalid_o === 1'b1) begin
        r = s_axi_rresp_o;
        d = s_axi_rdata_o;
        s_axi_rready_i <= 1'b0;
      end
      if (s_axi_arready_o === 1'b1 && s_axi_arvalid_i) begin
        a_ok = 1'b1;
        s_axi_arvalid_i <= 1'b0;
      end
    end
    if (r === 2'h1) timeout_hit;
    chk(d, ed);
    chk({30'h0, r}, {30'h0, er});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge mclk_i);
    @(negedge mclk_i);
  endtask
  task automatic wait_rise(input int n);
    for (int k = 0; k < 400 && rise_cnt < n; k++) @(posedge mclk_i);
    if (rise_cnt < n) timeout_hit;
    @(negedge mclk_i);
  endtask

  // ====================
  // Main sequence
  initial begin
    {rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} = 4'h0;
    {s_axi_arvalid_i, s_axi_rready_i, serial_ctl_pin0_i, serial_ctl_pin1_i} = 4'h0;
    s_axi_awaddr_i = 18'h00000;
    s_axi_araddr_i = 18'h00000;
    s_axi_wdata_i = 32'h0;
    s_axi_wstrb_i = 4'h0;
    repeat (12) @(posedge mclk_i);
    rstn_i <= 1'b1;
    rd(A_CA, 32'h0, RESP_OKAY);
    rd(A_CB, 32'h0, RESP_OKAY);
    rd(A_ST, 32'h40, RESP_OKAY);
    rd(18'h00000, 32'h0, RESP_SLVERR);
    wr(A_ST, 32'hFF, RESP_SLVERR);
    wr(A_CB, 32'h0C, RESP_OKAY);
    settle(1);
    chkb(serial_ctl_pin0_oe_n_o, 1'b1);
    wr(A_CA, 32'h101, RESP_OKAY);
    wr(A_CB, 32'h1D2D, RESP_OKAY);
    settle(2);
    chkb(tx_irq_o, 1'b1);
    chkb(serial_ctl_pin0_o, 1'b1);
    chkb(serial_ctl_pin1_o, 1'b0);
    chkb(serial_ctl_pin0_oe_n_o, 1'b0);
    chkb(bit_clk_oe_n_o, 1'b0);
    wr(A_DT, 32'hA50000, RESP_OKAY);
    rd(A_ST, 32'h0, RESP_OKAY);
    settle(1);
    chkb(tx_irq_o, 1'b0);
    wr(A_CB, 32'h5D2E, RESP_OKAY);
    settle(40);
    chk(32'(rise_cnt), 32'h0);
    chkb(tx_data_pin_oe_n_o, 1'b1);
    wr(A_CA, 32'h001, RESP_OKAY);
    wr(A_CB, 32'h5D2F, RESP_OKAY);
    wr(A_DT, 32'h3C0000, RESP_OKAY);
    wait_rise(4);
    chkb(serial_ctl_pin0_o, 1'b0);
    chkb(serial_ctl_pin1_o, 1'b1);
    chkb(tx_data_pin_oe_n_o, 1'b0);
    wait_rise(9);
    chkb(serial_ctl_pin0_o, 1'b1);
    wait_rise(16);
    settle(6);
    chkb(tx_data_pin_oe_n_o, 1'b1);
    chk({16'h0, peer.got[15:0]}, 32'hA53C);
    chk(32'(peer.bits), 32'd16);
    chkb(max_gap >= 12 && max_gap <= 20, 1'b1);
    settle(100);
    chk(32'(rise_cnt), 32'd16);
    chkb(bit_clk_o, 1'b0);
    rd(A_ST, 32'h40, RESP_OKAY);
    wr(A_CB, 32'hAD00, RESP_OKAY);
    serial_ctl_pin0_i <= 1'b1;
    settle(1);
    chkb(bit_clk_oe_n_o, 1'b1);
    chkb(serial_ctl_pin0_oe_n_o, 1'b1);
    fork
      peer.send(8'h3C);
      begin
        repeat (20) @(posedge mclk_i);
        serial_ctl_pin0_i <= 1'b0;
        serial_ctl_pin1_i <= 1'b1;
      end
    join
    settle(10);
    chkb(rx_irq_o, 1'b1);
    rd(A_ST, 32'hC1, RESP_OKAY);
    rd(A_DT, 32'h3C0000, RESP_OKAY);
    rd(A_ST, 32'h41, RESP_OKAY);
    settle(1);
    chkb(rx_irq_o, 1'b0);
    wr(A_CA, 32'h2001, RESP_OKAY);
    wr(A_CB, 32'hDD2F, RESP_OKAY);
    wr(A_DT, 32'hABC000, RESP_OKAY);
    wait_rise(20);
    chkb(serial_ctl_pin2_o, 1'b1);
    chkb(serial_ctl_pin2_oe_n_o, 1'b1);
    chkb(serial_ctl_pin1_oe_n_o, 1'b0);
    wait_rise(28);
    settle(6);
    chkb(serial_ctl_pin2_o, 1'b0);
    chk({20'h0, peer.got[11:0]}, 32'hABC);
    chk(32'(peer.bits), 32'h1C);
    rd(A_ST, 32'hC2, RESP_OKAY);
    rd(A_DT, 32'hFFF000, RESP_OKAY);
    final_report;
  end
endmodule
`default_nettype wire
